/* src/epm_pkg.sv */
// Purpose: Shared constants for the receive performance monitor counters
// Assumes: 100 MHz system clock, 5-bit host address within the status page
// Notes: Operation summary below, one line per behaviour
// Operation
// [R1] Window counter steps once per received CRC submultiframe
// [R2] Host write to pattern error counter clears the window counter
// [R3] Status word holds category code of the most recent interrupt
// [R4] Ten-bit far-end count: two high bits, then low byte; spare bits zero
// [R5] Jitter counter steps when read pointer nears underflow or overflow
// [R6] Near a limit, read clock is slowed or sped to avoid slips
// [R7] Latch bits 7..4 catch pattern, far-end, jitter, sync-loss overflows
// [R8] Latch bits 3..0 catch FAS bit, errored FAS, violation, CRC overflows
// [R9] Reading the overflow latch clears it; bits hold until that read
// [R10] Sync loss counter steps each frame period without basic alignment
// [R11] Sync loss counter clears on entry to loss of basic alignment
// [R12] FAS bit error counter accumulates every FAS word bit error
// [R13] Window flag: alarm-with-CRC condition lasted 10 ms to 450 ms; read clears
// [R14] Persist flag high while alarm-with-CRC condition exceeds 10 ms
// [R15] Errored FAS counter steps per FAS word holding any error
// [R16] Pattern error counter steps per checker pattern error
// [R17] Sixteen-bit line violation counter over two byte registers
// [R18] Counters wrap to zero on overflow and keep counting
// [R19] Counter reads leave the count unchanged unless clear effect given

package epm_pkg;

  // ==========================================================================
  // Register offsets within the status page
  localparam logic [4:0] EPM_OFS_PATTERN_ERR = 5'h10;
  localparam logic [4:0] EPM_OFS_WINDOW = 5'h11;
  localparam logic [4:0] EPM_OFS_IRQ_CAT = 5'h12;
  localparam logic [4:0] EPM_OFS_FAR_END_HI = 5'h13;
  localparam logic [4:0] EPM_OFS_FAR_END_LO = 5'h14;
  localparam logic [4:0] EPM_OFS_JITTER = 5'h15;
  localparam logic [4:0] EPM_OFS_OVF_LATCH = 5'h16;
  localparam logic [4:0] EPM_OFS_SYNC_LOSS = 5'h17;
  localparam logic [4:0] EPM_OFS_FAS_BIT = 5'h18;
  localparam logic [4:0] EPM_OFS_ALARM_CRC = 5'h19;
  localparam logic [4:0] EPM_OFS_ERR_FAS = 5'h1a;
  localparam logic [4:0] EPM_OFS_VIOL_HI = 5'h1c;
  localparam logic [4:0] EPM_OFS_VIOL_LO = 5'h1d;

  // ==========================================================================
  // Overflow latch bit positions
  localparam int EPM_OVF_PATTERN = 7;
  localparam int EPM_OVF_FAR_END = 6;
  localparam int EPM_OVF_JITTER = 5;
  localparam int EPM_OVF_SYNC_LOSS = 4;
  localparam int EPM_OVF_FAS_BIT = 3;
  localparam int EPM_OVF_ERR_FAS = 2;
  localparam int EPM_OVF_VIOL = 1;
  localparam int EPM_OVF_CRC = 0;

  // Alarm-with-CRC word bit positions
  localparam int EPM_ALARM_WINDOW_BIT = 1;
  localparam int EPM_ALARM_PERSIST_BIT = 0;

  // ==========================================================================
  // Byte counter slots in the generate array
  localparam int EPM_NCNT = 6;
  localparam int EPM_CNT_PATTERN = 0;
  localparam int EPM_CNT_WINDOW = 1;
  localparam int EPM_CNT_JITTER = 2;
  localparam int EPM_CNT_SYNC_LOSS = 3;
  localparam int EPM_CNT_FAS_BIT = 4;
  localparam int EPM_CNT_ERR_FAS = 5;

  // Widths and reset values
  localparam int EPM_BYTE_W = 8;
  localparam int EPM_FAR_END_W = 10;
  localparam int EPM_VIOL_W = 16;
  localparam int EPM_AMT_W = 3;
  localparam int EPM_PERSIST_W = 26;
  localparam logic [7:0] EPM_BYTE_ZERO = 8'h00;
  localparam logic [2:0] EPM_AMT_ONE = 3'h1;

  // ==========================================================================
  // Timing: persistence bounds in ms and derived cycle counts
  localparam int EPM_CLK_HZ = 100_000_000;
  localparam int EPM_PERSIST_MIN_MS = 10;
  localparam int EPM_PERSIST_MAX_MS = 450;
  localparam int EPM_PERSIST_MIN_CYC = EPM_PERSIST_MIN_MS * (EPM_CLK_HZ / 1000);
  localparam int EPM_PERSIST_MAX_CYC = EPM_PERSIST_MAX_MS * (EPM_CLK_HZ / 1000);

endpackage : epm_pkg

/* src/epm_evt_counter.sv */
// Purpose: Wrapping event counter with overflow pulse
// Assumes: Clear and increment are synchronous, clear takes priority
// Notes: Overflow pulse is combinational in the carrying cycle
`timescale 1ns/1ps
`default_nettype none

module epm_evt_counter
  import epm_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clr,
  input wire logic inc,
  input wire logic [EPM_AMT_W-1:0] amt,
  output logic [W-1:0] count,
  output logic ovf
);

  // ==========================================================================
  // Sum with carry out
  logic [W:0] sum_nxt;
  logic [W-1:0] count_r;

  assign sum_nxt = {1'b0, count_r} + {{(W+1-EPM_AMT_W){1'b0}}, amt};
  assign ovf = inc && !clr && sum_nxt[W]; // R18
  assign count = count_r;

  // Carry is dropped so the count wraps and keeps running
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_r <= '0;
    end else if (clr) begin
      count_r <= '0;
    end else if (inc) begin
      count_r <= sum_nxt[W-1:0]; // R18
    end
  end

endmodule : epm_evt_counter

`default_nettype wire

/* src/epm_monitor.sv */
// Purpose: Receive performance monitor counters and latched status
// Assumes: Event inputs are one-cycle pulses synchronous to sys_clk
// Notes: Host read and write strobes are one-cycle pulses qualified by cs
`timescale 1ns/1ps
`default_nettype none

module epm_monitor
  import epm_pkg::*;
#(
  parameter int PERSIST_MIN_CYC = EPM_PERSIST_MIN_CYC,
  parameter int PERSIST_MAX_CYC = EPM_PERSIST_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [4:0] host_addr,
  output logic [7:0] host_rdata,
  input wire logic prbs_err_evt,
  input wire logic crc_submf_evt,
  input wire logic irq_vec_load,
  input wire logic [7:0] irq_vec,
  input wire logic febe_evt,
  input wire logic jit_near_under,
  input wire logic jit_near_over,
  output logic read_clk_slow,
  output logic read_clk_fast,
  input wire logic frame_tick,
  input wire logic bfa_lost,
  input wire logic fas_word_evt,
  input wire logic [2:0] fas_err_bits,
  input wire logic bpv_evt,
  input wire logic crc_cnt_ovf,
  input wire logic rx_rai_bit,
  input wire logic rx_e_bit,
  output logic alarm_crc_persist
);

  // ==========================================================================
  // Host access decode
  logic rd_stb;
  logic wr_stb;
  logic rd_latch;
  logic rd_alarm;
  logic wr_pattern;

  assign rd_stb = host_cs && host_rd;
  assign wr_stb = host_cs && host_wr;
  assign rd_latch = rd_stb && (host_addr == EPM_OFS_OVF_LATCH);
  assign rd_alarm = rd_stb && (host_addr == EPM_OFS_ALARM_CRC);
  assign wr_pattern = wr_stb && (host_addr == EPM_OFS_PATTERN_ERR);

  // ==========================================================================
  // Byte counters
  logic [EPM_NCNT-1:0] cnt_clr;
  logic [EPM_NCNT-1:0] cnt_inc;
  logic [EPM_AMT_W-1:0] cnt_amt [EPM_NCNT];
  logic [EPM_BYTE_W-1:0] cnt_val [EPM_NCNT];
  logic [EPM_NCNT-1:0] cnt_ovf;
  logic jit_near;
  logic jit_near_r;
  logic bfa_lost_r;
  logic sync_loss_entry;

  assign jit_near = jit_near_under || jit_near_over;
  assign sync_loss_entry = bfa_lost && !bfa_lost_r;

  // Delayed levels for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      jit_near_r <= 1'b0;
      bfa_lost_r <= 1'b0;
    end else begin
      jit_near_r <= jit_near;
      bfa_lost_r <= bfa_lost;
    end
  end

  // Per-counter clear and increment wiring
  always_comb begin
    cnt_clr = '0;
    cnt_inc = '0;
    for (int i = 0; i < EPM_NCNT; i++) begin
      cnt_amt[i] = EPM_AMT_ONE;
    end
    cnt_inc[EPM_CNT_PATTERN] = prbs_err_evt; // R16
    cnt_inc[EPM_CNT_WINDOW] = crc_submf_evt; // R1
    cnt_clr[EPM_CNT_WINDOW] = wr_pattern; // R2
    // Counts once per approach, not every cycle spent near the limit
    cnt_inc[EPM_CNT_JITTER] = jit_near && !jit_near_r; // R5
    // Clear wins when a frame tick lands on the loss-entry cycle
    cnt_inc[EPM_CNT_SYNC_LOSS] = frame_tick && bfa_lost; // R10
    cnt_clr[EPM_CNT_SYNC_LOSS] = sync_loss_entry; // R11
    cnt_inc[EPM_CNT_FAS_BIT] = fas_word_evt; // R12
    cnt_amt[EPM_CNT_FAS_BIT] = fas_err_bits; // R12
    cnt_inc[EPM_CNT_ERR_FAS] = fas_word_evt && (fas_err_bits != '0); // R15
  end

  genvar g;
  generate
    for (g = 0; g < EPM_NCNT; g++) begin : g_cnt
      epm_evt_counter #(.W(EPM_BYTE_W)) u_cnt (
        .sys_clk(sys_clk),
        .srst(srst),
        .clr(cnt_clr[g]),
        .inc(cnt_inc[g]),
        .amt(cnt_amt[g]),
        .count(cnt_val[g]),
        .ovf(cnt_ovf[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Wide counters: far-end errors and line violations
  logic [EPM_FAR_END_W-1:0] far_end_cnt;
  logic far_end_ovf;
  logic [EPM_VIOL_W-1:0] viol_cnt;
  logic viol_ovf;

  epm_evt_counter #(.W(EPM_FAR_END_W)) u_far_end (
    .sys_clk(sys_clk),
    .srst(srst),
    .clr(1'b0),
    .inc(febe_evt),
    .amt(EPM_AMT_ONE),
    .count(far_end_cnt),
    .ovf(far_end_ovf)
  );

  epm_evt_counter #(.W(EPM_VIOL_W)) u_viol (
    .sys_clk(sys_clk),
    .srst(srst),
    .clr(1'b0),
    .inc(bpv_evt), // R17
    .amt(EPM_AMT_ONE),
    .count(viol_cnt),
    .ovf(viol_ovf)
  );

  // ==========================================================================
  // Overflow latch, set beats the clear-on-read
  logic [7:0] ovf_set;
  logic [7:0] ovf_latch_r;

  always_comb begin
    ovf_set = EPM_BYTE_ZERO;
    ovf_set[EPM_OVF_PATTERN] = cnt_ovf[EPM_CNT_PATTERN]; // R7
    ovf_set[EPM_OVF_FAR_END] = far_end_ovf; // R7
    ovf_set[EPM_OVF_JITTER] = cnt_ovf[EPM_CNT_JITTER]; // R7
    ovf_set[EPM_OVF_SYNC_LOSS] = cnt_ovf[EPM_CNT_SYNC_LOSS]; // R7
    ovf_set[EPM_OVF_FAS_BIT] = cnt_ovf[EPM_CNT_FAS_BIT]; // R8
    ovf_set[EPM_OVF_ERR_FAS] = cnt_ovf[EPM_CNT_ERR_FAS]; // R8
    ovf_set[EPM_OVF_VIOL] = viol_ovf; // R8
    ovf_set[EPM_OVF_CRC] = crc_cnt_ovf; // R8
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovf_latch_r <= EPM_BYTE_ZERO;
    end else if (rd_latch) begin
      ovf_latch_r <= ovf_set; // R9
    end else begin
      ovf_latch_r <= ovf_latch_r | ovf_set; // R9
    end
  end

  // ==========================================================================
  // Last interrupt category
  logic [7:0] irq_cat_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_cat_r <= EPM_BYTE_ZERO;
    end else if (irq_vec_load) begin
      irq_cat_r <= irq_vec; // R3
    end
  end

  // ==========================================================================
  // Jitter buffer read clock steering
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      read_clk_slow <= 1'b0;
      read_clk_fast <= 1'b0;
    end else begin
      // Near underflow: read slower; near overflow: read faster
      read_clk_slow <= jit_near_under; // R6
      read_clk_fast <= jit_near_over; // R6
    end
  end

  // ==========================================================================
  // Alarm with continuous CRC error persistence
  logic alarm_cond;
  logic alarm_cond_r;
  logic [EPM_PERSIST_W-1:0] persist_cnt_r;
  logic [EPM_PERSIST_W-1:0] persist_min;
  logic [EPM_PERSIST_W-1:0] persist_max;
  logic window_hit;
  logic alarm_window_r;

  assign alarm_cond = rx_rai_bit && !rx_e_bit;
  assign persist_min = PERSIST_MIN_CYC[EPM_PERSIST_W-1:0];
  assign persist_max = PERSIST_MAX_CYC[EPM_PERSIST_W-1:0];
  // Duration is judged when the condition ends
  assign window_hit = alarm_cond_r && !alarm_cond &&
                      (persist_cnt_r > persist_min) && (persist_cnt_r < persist_max);

  // Saturates just past the upper bound so a long alarm never wraps back in range
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      persist_cnt_r <= '0;
      alarm_cond_r <= 1'b0;
    end else begin
      alarm_cond_r <= alarm_cond;
      if (!alarm_cond) begin
        persist_cnt_r <= '0;
      end else if (persist_cnt_r <= persist_max) begin
        persist_cnt_r <= persist_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarm_crc_persist <= 1'b0;
    end else begin
      alarm_crc_persist <= alarm_cond && (persist_cnt_r >= persist_min); // R14
    end
  end

  // Set wins over a same-cycle read
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarm_window_r <= 1'b0;
    end else if (window_hit) begin
      alarm_window_r <= 1'b1; // R13
    end else if (rd_alarm) begin
      alarm_window_r <= 1'b0; // R13
    end
  end

  // ==========================================================================
  // Read data mux, registered; unmapped offsets read zero
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = EPM_BYTE_ZERO;
    case (host_addr)
      EPM_OFS_PATTERN_ERR: rdata_nxt = cnt_val[EPM_CNT_PATTERN]; // R19
      EPM_OFS_WINDOW: rdata_nxt = cnt_val[EPM_CNT_WINDOW];
      EPM_OFS_IRQ_CAT: rdata_nxt = irq_cat_r; // R3
      EPM_OFS_FAR_END_HI: rdata_nxt = {6'h00, far_end_cnt[9:8]}; // R4
      EPM_OFS_FAR_END_LO: rdata_nxt = far_end_cnt[7:0]; // R4
      EPM_OFS_JITTER: rdata_nxt = cnt_val[EPM_CNT_JITTER];
      EPM_OFS_OVF_LATCH: rdata_nxt = ovf_latch_r;
      EPM_OFS_SYNC_LOSS: rdata_nxt = cnt_val[EPM_CNT_SYNC_LOSS];
      EPM_OFS_FAS_BIT: rdata_nxt = cnt_val[EPM_CNT_FAS_BIT];
      EPM_OFS_ALARM_CRC: rdata_nxt = {6'h00, alarm_window_r, alarm_crc_persist};
      EPM_OFS_ERR_FAS: rdata_nxt = cnt_val[EPM_CNT_ERR_FAS];
      EPM_OFS_VIOL_HI: rdata_nxt = viol_cnt[15:8]; // R17
      EPM_OFS_VIOL_LO: rdata_nxt = viol_cnt[7:0]; // R17
      default: rdata_nxt = EPM_BYTE_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      host_rdata <= EPM_BYTE_ZERO;
    end else if (rd_stb) begin
      host_rdata <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_WINDOW_INC: assert property ( // R1
    crc_submf_evt && !wr_pattern |=>
      cnt_val[EPM_CNT_WINDOW] == $past(cnt_val[EPM_CNT_WINDOW]) + 8'h01)
    else $error("window counter did not step");

  AST_WINDOW_CLR: assert property ( // R2
    wr_pattern |=> cnt_val[EPM_CNT_WINDOW] == EPM_BYTE_ZERO)
    else $error("window counter not cleared by write");

  AST_IRQ_CAT: assert property ( // R3
    irq_vec_load |=> irq_cat_r == $past(irq_vec))
    else $error("interrupt category not captured");

  AST_FAR_END_HI: assert property ( // R4
    rd_stb && host_addr == EPM_OFS_FAR_END_HI |=>
      host_rdata == {6'h00, $past(far_end_cnt[9:8])})
    else $error("far-end high read wrong");

  AST_JIT_INC: assert property ( // R5
    jit_near && !jit_near_r |=>
      cnt_val[EPM_CNT_JITTER] == $past(cnt_val[EPM_CNT_JITTER]) + 8'h01)
    else $error("jitter counter did not step");

  AST_JIT_STEER: assert property ( // R6
    jit_near_under && !jit_near_over |=> read_clk_slow && !read_clk_fast)
    else $error("read clock not slowed near underflow");

  AST_OVF_SET: assert property ( // R7
    cnt_ovf[EPM_CNT_PATTERN] |=> ovf_latch_r[EPM_OVF_PATTERN] ##1
      (ovf_latch_r[EPM_OVF_PATTERN] || $past(rd_latch)))
    else $error("pattern overflow not latched");

  AST_OVF_CRC: assert property ( // R8
    crc_cnt_ovf |=> ovf_latch_r[EPM_OVF_CRC])
    else $error("CRC overflow not latched");

  AST_OVF_RD_CLR: assert property ( // R9
    rd_latch && ovf_set == EPM_BYTE_ZERO |=> ovf_latch_r == EPM_BYTE_ZERO)
    else $error("overflow latch not cleared by read");

  AST_SYNC_LOSS_INC: assert property ( // R10
    frame_tick && bfa_lost && bfa_lost_r |=>
      cnt_val[EPM_CNT_SYNC_LOSS] == $past(cnt_val[EPM_CNT_SYNC_LOSS]) + 8'h01)
    else $error("sync loss counter did not step");

  AST_SYNC_LOSS_CLR: assert property ( // R11
    $rose(bfa_lost) |=> cnt_val[EPM_CNT_SYNC_LOSS] == EPM_BYTE_ZERO)
    else $error("sync loss counter not cleared on entry");

  AST_FAS_BIT_ADD: assert property ( // R12
    fas_word_evt |=> cnt_val[EPM_CNT_FAS_BIT] ==
      8'($past(cnt_val[EPM_CNT_FAS_BIT]) + $past(fas_err_bits)))
    else $error("FAS bit errors not accumulated");

  AST_PERSIST: assert property ( // R14
    alarm_crc_persist |-> $past(alarm_cond) && $past(persist_cnt_r) >= persist_min)
    else $error("persist flag without long alarm");

  AST_WINDOW_FLAG: assert property ( // R13
    window_hit |=> alarm_window_r [*2] or ##1 $past(rd_alarm))
    else $error("window flag not held");

endmodule : epm_monitor

`default_nettype wire

/* verification/epm_host_model.sv */
// Purpose: Host processor model driving the monitor's parallel status port
// Assumes: One-cycle strobes, launched just after a rising edge
// Notes: Read data is taken one settle step after the strobe edge
`timescale 1ns/1ps
`default_nettype none

module epm_host_model (
  input wire logic sys_clk,
  output logic host_cs,
  output logic host_rd,
  output logic host_wr,
  output logic [4:0] host_addr,
  input wire logic [7:0] host_rdata
);
  // ==========================================================================
  // Idle bus at time zero
  initial begin
    host_cs = 1'b0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 5'h00;
  end
  // ==========================================================================
  // One access: strobe up after an edge, taken and dropped at the next edge
  task automatic access(input logic [4:0] a, input logic w, output logic [7:0] d);
    @(posedge sys_clk);
    host_cs <= 1'b1;
    host_rd <= ~w;
    host_wr <= w;
    host_addr <= a;
    @(posedge sys_clk);
    host_cs <= 1'b0;
    host_rd <= 1'b0;
    host_wr <= 1'b0;
    host_addr <= ~a;  // Released address moves, so nothing leans on a stale value
    #1;
    d = host_rdata;
  endtask : access
endmodule : epm_host_model
`default_nettype wire

/* verification/tb_e1_performance_monitor_counters.sv */
// Purpose: Self-checking bench for the receive performance monitor
// Assumes: Persistence bounds shortened to 20 and 100 cycles
// Notes: Plain counts run from a table; reset and edge cases follow
`timescale 1ns/1ps
`default_nettype none

module tb_e1_performance_monitor_counters import epm_pkg::*; ();
  localparam int MIN_C = 20;
  localparam int MAX_C = 100;
  localparam int LIMIT = 90000;
  typedef struct packed {
    logic [2:0] ev;
    logic [7:0] n;
    logic [7:0] d;
    logic [4:0] a;
    logic [7:0] exp;
  } epm_row_type;
  // Event bits: 0 pattern, 1 submultiframe, 2 far-end, 3 frame, 4 FAS, 5 violation
  localparam epm_row_type ROWS [12] = '{
    '{3'd0, 8'd3, 8'h00, EPM_OFS_PATTERN_ERR, 8'h03},
    '{3'd0, 8'd0, 8'h00, EPM_OFS_PATTERN_ERR, 8'h03},
    '{3'd1, 8'd5, 8'h00, EPM_OFS_WINDOW, 8'h05},
    '{3'd2, 8'd2, 8'h00, EPM_OFS_FAR_END_LO, 8'h02},
    '{3'd2, 8'd0, 8'h00, EPM_OFS_FAR_END_HI, 8'h00},
    '{3'd5, 8'd4, 8'h00, EPM_OFS_VIOL_LO, 8'h04},
    '{3'd5, 8'd0, 8'h00, EPM_OFS_VIOL_HI, 8'h00},
    '{3'd4, 8'd2, 8'h03, EPM_OFS_FAS_BIT, 8'h06},
    '{3'd4, 8'd3, 8'h00, EPM_OFS_ERR_FAS, 8'h02},
    '{3'd7, 8'd1, 8'h5a, EPM_OFS_IRQ_CAT, 8'h5a},
    '{3'd0, 8'd0, 8'h00, 5'h1b, 8'h00},
    '{3'd0, 8'd0, 8'h00, 5'h1e, 8'h00}
  };
  localparam int DUR [3] = '{40, 10, 120};
  localparam logic [7:0] WEXP [3] = '{8'h02, 8'h00, 8'h00};

  logic sys_clk;
  logic srst = 1'b1;
  logic host_cs, host_rd, host_wr, read_clk_slow, read_clk_fast, alarm_crc_persist;
  logic [4:0] host_addr;
  logic [7:0] host_rdata, wd;
  logic [7:0] evt = 8'h00;
  logic [7:0] irq_vec = 8'h00;
  logic [2:0] fas_err_bits = 3'h0;
  logic jit_near_under = 1'b0;
  logic jit_near_over = 1'b0;
  logic bfa_lost = 1'b0;
  logic rx_rai_bit = 1'b0;
  logic rx_e_bit = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  // ==========================================================================
  // Design, host model and clock
  epm_monitor #(.PERSIST_MIN_CYC(MIN_C), .PERSIST_MAX_CYC(MAX_C)) dut_u (
    .sys_clk(sys_clk), .srst(srst), .host_cs(host_cs), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr), .host_rdata(host_rdata),
    .prbs_err_evt(evt[0]), .crc_submf_evt(evt[1]), .irq_vec_load(evt[7]),
    .irq_vec(irq_vec), .febe_evt(evt[2]), .jit_near_under(jit_near_under),
    .jit_near_over(jit_near_over), .read_clk_slow(read_clk_slow),
    .read_clk_fast(read_clk_fast), .frame_tick(evt[3]), .bfa_lost(bfa_lost),
    .fas_word_evt(evt[4]), .fas_err_bits(fas_err_bits), .bpv_evt(evt[5]),
    .crc_cnt_ovf(evt[6]), .rx_rai_bit(rx_rai_bit), .rx_e_bit(rx_e_bit),
    .alarm_crc_persist(alarm_crc_persist)
  );
  epm_host_model host_u (
    .sys_clk(sys_clk), .host_cs(host_cs), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_rdata(host_rdata)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard: the longest run is the 16-bit wrap, near 65.5k cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      summarize();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // Pulses one event input for n back-to-back cycles; the FAS bit count adds d each cycle
  task automatic fire(input int b, input int n, input logic [7:0] d);
    if (n > 0) begin
      @(posedge sys_clk);
      evt <= 8'h01 << b;
      fas_err_bits <= d[2:0];
      irq_vec <= d;
      repeat (n) @(posedge sys_clk);
      evt <= 8'h00;
    end
  endtask : fire

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.access(a, 1'b0, d);
    chk8(d, exp);
  endtask : rchk

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    foreach (ROWS[i]) begin
      fire(int'(ROWS[i].ev), int'(ROWS[i].n), ROWS[i].d);
      rchk(ROWS[i].a, ROWS[i].exp);
    end
    // Writing the pattern counter restarts only the window count
    host_u.access(EPM_OFS_PATTERN_ERR, 1'b1, wd);
    rchk(EPM_OFS_WINDOW, 8'h00);
    rchk(EPM_OFS_PATTERN_ERR, 8'h03);
    // Frames count only while alignment is lost; a new loss restarts the count
    @(posedge sys_clk) bfa_lost <= 1'b1;
    fire(3, 3, 8'h00);
    rchk(EPM_OFS_SYNC_LOSS, 8'h03);
    @(posedge sys_clk) bfa_lost <= 1'b0;
    fire(3, 2, 8'h00);
    rchk(EPM_OFS_SYNC_LOSS, 8'h03);
    @(posedge sys_clk) bfa_lost <= 1'b1;
    rchk(EPM_OFS_SYNC_LOSS, 8'h00);
    // A long stay near a limit counts once and steers the read clock
    @(posedge sys_clk) jit_near_under <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk8({6'h00, read_clk_slow, read_clk_fast}, 8'h02);
    @(posedge sys_clk) jit_near_under <= 1'b0;  // Leaves the limit: the next approach is new
    @(posedge sys_clk) jit_near_over <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk8({6'h00, read_clk_slow, read_clk_fast}, 8'h01);
    @(posedge sys_clk) jit_near_over <= 1'b0;
    rchk(EPM_OFS_JITTER, 8'h02);
    // Alarm-with-CRC spells: inside the window, too short, too long
    foreach (DUR[i]) begin
      @(posedge sys_clk) {rx_rai_bit, rx_e_bit} <= 2'b10;
      repeat (DUR[i]) @(posedge sys_clk);
      #1 chk8({7'h00, alarm_crc_persist}, (DUR[i] > MIN_C) ? 8'h01 : 8'h00);
      @(posedge sys_clk) {rx_rai_bit, rx_e_bit} <= 2'b01;
      repeat (3) @(posedge sys_clk);
      rchk(EPM_OFS_ALARM_CRC, WEXP[i]);
      rchk(EPM_OFS_ALARM_CRC, 8'h00);
    end
    // Drive every latched counter through its wrap; latch bits wait for the read
    fire(0, 253, 8'h00);
    fire(2, 1021, 8'h00);
    rchk(EPM_OFS_FAR_END_HI, 8'h03);
    rchk(EPM_OFS_FAR_END_LO, 8'hff);
    rchk(EPM_OFS_OVF_LATCH, 8'h80);
    fire(2, 1, 8'h00);
    for (int i = 0; i < 254; i++) begin
      @(posedge sys_clk) jit_near_over <= 1'b1;
      @(posedge sys_clk) jit_near_over <= 1'b0;
    end
    fire(3, 256, 8'h00);
    fire(4, 250, 8'h01);
    fire(4, 4, 8'h01);
    fire(5, 65532, 8'h00);
    fire(6, 1, 8'h00);
    rchk(EPM_OFS_OVF_LATCH, 8'h7f);
    rchk(EPM_OFS_OVF_LATCH, 8'h00);
    rchk(EPM_OFS_FAS_BIT, 8'h04);
    rchk(EPM_OFS_VIOL_HI, 8'h00);
    fire(0, 1, 8'h00);
    rchk(EPM_OFS_PATTERN_ERR, 8'h01);
    // Reset in mid-run returns the whole page to zero
    @(posedge sys_clk) srst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (int a = 16; a < 32; a++) rchk(5'(a), 8'h00);
    summarize();
  end
endmodule : tb_e1_performance_monitor_counters
`default_nettype wire
